// [bench/ocwd_nv_model.sv]
// Model of the non-volatile word source feeding the decoder.
// Assumes one clock and a synchronous active-low reset from the bench.
module ocwd_nv_model #(
  parameter int VALID_DLY = 5
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  // Word to present
  input  wire logic [13:0] word_i,
  // To the decoder
  output logic      [13:0] nv_word_o,
  output logic             word_valid_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] cnt_q;

  // --------------------------------------------------------------
  // Read-out sequence
  // --------------------------------------------------------------
  // Lines churn until the read settles, so an early capture shows
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      cnt_q        <= 8'h00;
      word_valid_o <= 1'b0;
      nv_word_o    <= ~word_i;
    end
    else
    begin
      if (cnt_q <= VALID_DLY[7:0]) cnt_q <= cnt_q + 8'h01;
      nv_word_o    <= (cnt_q < VALID_DLY[7:0]) ? ~nv_word_o : word_i;
      // Valid one edge after the word, never together with it
      word_valid_o <= (cnt_q > VALID_DLY[7:0]);
    end
  end
endmodule // ocwd_nv_model

// [bench/oscillator_config_word_decode_tb.sv]
// Testbench for the oscillator configuration word decoder.
// Assumes the word source model and the register port of ocwd_top.
module oscillator_config_word_decode_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic                ref_clk_i;
  logic                reset_n_i;
  logic [13:0]         nv_word;
  logic                word_valid;
  logic [3:0]          addr_i;
  logic [15:0]         wdata_i;
  logic                wr_i;
  logic                rd_i;
  logic [15:0]         rdata_o;
  ocwd_pkg::ocwd_cfg_t cfg_o;
  logic [2:0]          new_osc_select_o;
  logic [3:0]          new_divider_select_o;
  logic                loaded_o;
  logic                write_blocked_o;
  logic                osc2_out_o;
  logic                osc2_oe_n_o;
  logic [13:0]         word_sel;
  logic [13:0]         w;
  logic [15:0]         d;
  logic [2:0]          k;
  logic                f4;
  logic                a;
  int                  bad_count;
  int                  checked;
  int                  n;

  ocwd_nv_model nvm (
    .ref_clk_i    (ref_clk_i),
    .reset_n_i    (reset_n_i),
    .word_i       (word_sel),
    .nv_word_o    (nv_word),
    .word_valid_o (word_valid)
  );

  ocwd_top dut (
    .ref_clk_i            (ref_clk_i),
    .reset_n_i            (reset_n_i),
    .nv_word_i            (nv_word),
    .word_valid_i         (word_valid),
    .addr_i               (addr_i),
    .wdata_i              (wdata_i),
    .wr_i                 (wr_i),
    .rd_i                 (rd_i),
    .rdata_o              (rdata_o),
    .cfg_o                (cfg_o),
    .new_osc_select_o     (new_osc_select_o),
    .new_divider_select_o (new_divider_select_o),
    .loaded_o             (loaded_o),
    .write_blocked_o      (write_blocked_o),
    .osc2_out_o           (osc2_out_o),
    .osc2_oe_n_o          (osc2_oe_n_o)
  );

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe; returns once the update has landed
  task automatic wr_reg(input logic [3:0] ad, input logic [15:0] dt);
    addr_i  <= ad;
    wdata_i <= dt;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] ad, output logic [15:0] dt);
    addr_i <= ad;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i   <= 1'b0;
    #1;
    dt = rdata_o;
  endtask

  task automatic give_verdict();
    $display("Mismatches %0d, comparisons %0d", bad_count, checked);
    if (bad_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // --------------------------------------------------------------
  // Clock and watchdog
  // --------------------------------------------------------------
  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // Whole run is well under a thousand cycles
  initial
  begin
    #200us;
    bad_count++;
    give_verdict();
  end

  // --------------------------------------------------------------
  // Tests: one reset per code, so every field value is captured
  // --------------------------------------------------------------
  initial
  begin
    reset_n_i = 1'b0;
    addr_i    = 4'h0;
    wdata_i   = 16'h0000;
    wr_i      = 1'b0;
    rd_i      = 1'b0;
    word_sel  = 14'h0000;
    bad_count = 0;
    checked   = 0;
    for (int i = 0; i < 8; i++)
    begin
      k = i[2:0];
      w = 14'h0000;
      w[13] = k[1];
      w[11] = k[0];
      w[8] = k[0] ^ k[1];
      w[6:4] = k;
      w[2:0] = k;
      // Unused bits both clear and set in the source word
      if (k[1]) w = w | ~ocwd_pkg::USED_MASK;
      f4 = (k >= 3'h5) && !w[8];
      reset_n_i <= 1'b0;
      word_sel  <= w;
      repeat (20) @(posedge ref_clk_i);
      chk({13'h0000, loaded_o, write_blocked_o, osc2_oe_n_o}, 16'h0001);
      reset_n_i <= 1'b1;
      n = 0;
      while (loaded_o !== 1'b1 && n < 40)
      begin
        @(posedge ref_clk_i);
        #1;
        n++;
      end
      chk(loaded_o, 1'b1);
      wr_reg(ocwd_pkg::OFS_CFG_WORD, 16'h0000);
      rd_reg(ocwd_pkg::OFS_CFG_WORD, d);
      chk(d, {2'b00, w | ~ocwd_pkg::USED_MASK});
      chk(cfg_o.failsafe_monitor_enable, w[13]);
      chk(cfg_o.clock_switch_permit, w[11]);
      chk(cfg_o.clock_out_enable, w[8]);
      chk(cfg_o.reset_osc_select, w[6:4]);
      chk(new_osc_select_o, w[6:4]);
      chk(cfg_o.external_osc_mode, w[2:0]);
      chk(cfg_o.ext_clock_input, k >= 3'h5);
      chk(cfg_o.crystal_mode, k <= 3'h2);
      chk(cfg_o.osc_pin_is_io, k == 3'h4);
      chk(cfg_o.reserved_code, k == 3'h3);
      chk(cfg_o.fosc4_on_pin, f4);
      chk(osc2_oe_n_o, !f4);
      if (f4)
      begin
        a = osc2_out_o;
        repeat (2) @(posedge ref_clk_i);
        #1;
        chk(osc2_out_o ^ a, 1'b1);
      end
      else
        chk(osc2_out_o, 1'b0);
      rd_reg(4'hf, d);
      chk(d, 16'h0000);
      // Switch request goes through only with the permit bit set
      wr_reg(ocwd_pkg::OFS_OSC_CTRL, 16'h0095);
      chk(new_osc_select_o, w[11] ? 3'h5 : w[6:4]);
      chk(new_divider_select_o, w[11] ? 4'h9 : 4'h0);
      chk(write_blocked_o, !w[11]);
      rd_reg(ocwd_pkg::OFS_OSC_CTRL, d);
      chk(d, w[11] ? 16'h0095 : {13'h0000, w[6:4]});
      rd_reg(ocwd_pkg::OFS_STATUS, d);
      chk(d, {14'h0000, !w[11], 1'b1});
      rd_reg(ocwd_pkg::OFS_STATUS, d);
      chk(d, 16'h0001);
    end
    give_verdict();
  end
endmodule // oscillator_config_word_decode_tb

// [include/ocwd_pkg.sv]
// Package for the oscillator configuration word decoder.
// Assumes a single 100 MHz clock and a synchronous active-low reset.
package ocwd_pkg;

  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int          WORD_W         = 14;
  localparam int          FSCM_BIT       = 13;
  localparam int          CSW_BIT        = 11;
  localparam int          CLKOUT_BIT     = 8;
  localparam int          RESET_SRC_HI   = 6;
  localparam int          RESET_SRC_LO   = 4;
  localparam int          EXTMODE_HI     = 2;
  localparam int          EXTMODE_LO     = 0;
  // Mask of implemented bits; all others read as one
  localparam logic [13:0] USED_MASK      = 14'h2977;
  localparam logic [13:0] ERASED_WORD    = 14'h3fff;

  // ----------------------------------------------------------------
  // Register map (word index on the plain port)
  // ----------------------------------------------------------------
  localparam logic [3:0]  ADDR_W         = 4'h4;
  localparam logic [3:0]  OFS_CFG_WORD   = 4'h0;
  localparam logic [3:0]  OFS_OSC_CTRL   = 4'h1;
  localparam logic [3:0]  OFS_STATUS     = 4'h2;
  localparam int          NEW_OSC_LO     = 0;
  localparam int          NEW_DIV_LO     = 4;
  localparam logic [2:0]  NEW_OSC_RESET  = 3'h0;
  localparam logic [3:0]  NEW_DIV_RESET  = 4'h0;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OCWD_SRC_INT32   = 3'h0,
    OCWD_SRC_INT2X   = 3'h1,
    OCWD_SRC_EXTPLL  = 3'h2,
    OCWD_SRC_RSVD    = 3'h3,
    OCWD_SRC_SEC     = 3'h4,
    OCWD_SRC_INTLOW  = 3'h5,
    OCWD_SRC_INTHI1M = 3'h6,
    OCWD_SRC_EXTDIR  = 3'h7
  } ocwd_src_t;

  typedef enum logic [2:0] {
    OCWD_EXT_LP      = 3'h0,
    OCWD_EXT_XT      = 3'h1,
    OCWD_EXT_HS      = 3'h2,
    OCWD_EXT_RSVD    = 3'h3,
    OCWD_EXT_OFF     = 3'h4,
    OCWD_EXT_ECL     = 3'h5,
    OCWD_EXT_ECM     = 3'h6,
    OCWD_EXT_ECH     = 3'h7
  } ocwd_ext_t;

  // Decoded selections for the oscillator and switch logic
  typedef struct packed {
    ocwd_src_t  reset_osc_select;
    ocwd_ext_t  external_osc_mode;
    logic       failsafe_monitor_enable;
    logic       clock_switch_permit;
    logic       clock_out_enable;
    logic       ext_clock_input;
    logic       crystal_mode;
    logic       osc_pin_is_io;
    logic       fosc4_on_pin;
    logic       reserved_code;
  } ocwd_cfg_t;

endpackage : ocwd_pkg

// [src/ocwd_decode.sv]
// Combinational field decoder for the oscillator configuration word.
// Assumes the word is already captured; no state of its own.
module ocwd_decode (
  // Raw word
  input  wire logic [13:0]        word_i,
  // Decoded fields
  output ocwd_pkg::ocwd_cfg_t      cfg_o
);

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  ocwd_pkg::ocwd_ext_t mode;
  logic                is_ext_clk;

  // Fields pulled from their fixed positions
  always_comb
  begin
    mode       = ocwd_pkg::ocwd_ext_t'(word_i[ocwd_pkg::EXTMODE_HI:ocwd_pkg::EXTMODE_LO]);
    is_ext_clk = (mode == ocwd_pkg::OCWD_EXT_ECH) || (mode == ocwd_pkg::OCWD_EXT_ECM)
              || (mode == ocwd_pkg::OCWD_EXT_ECL);
    cfg_o.reset_osc_select        = ocwd_pkg::ocwd_src_t'(word_i[ocwd_pkg::RESET_SRC_HI:ocwd_pkg::RESET_SRC_LO]);
    cfg_o.external_osc_mode       = mode;
    cfg_o.failsafe_monitor_enable = word_i[ocwd_pkg::FSCM_BIT];
    cfg_o.clock_switch_permit     = word_i[ocwd_pkg::CSW_BIT];
    cfg_o.clock_out_enable        = word_i[ocwd_pkg::CLKOUT_BIT];
    cfg_o.ext_clock_input         = is_ext_clk;
    cfg_o.crystal_mode            = (mode == ocwd_pkg::OCWD_EXT_HS) || (mode == ocwd_pkg::OCWD_EXT_XT)
                                 || (mode == ocwd_pkg::OCWD_EXT_LP);
    // Pin freed for I/O only when the oscillator is off
    cfg_o.osc_pin_is_io           = (mode == ocwd_pkg::OCWD_EXT_OFF);
    // Clock-out bit matters only in external clock modes; active low
    cfg_o.fosc4_on_pin            = is_ext_clk && !word_i[ocwd_pkg::CLKOUT_BIT];
    cfg_o.reserved_code           = (mode == ocwd_pkg::OCWD_EXT_RSVD)
                                 || (word_i[ocwd_pkg::RESET_SRC_HI:ocwd_pkg::RESET_SRC_LO] == 3'h3);
  end

endmodule // ocwd_decode

// [src/ocwd_top.sv]
// Oscillator configuration word decoder: captures the non-volatile word at
// power-up, decodes it, guards the clock-switch request registers.
// Assumes the word source is stable whenever word_valid_i is high and
// that reset_n_i is asserted on power-on and brown-out.
//
// Operation
// - Word bits 13 failsafe, 11 switch permit, 8 clock out, 6-4 reset source, 2-0 mode.
// - Switch permit zero blocks software writes to new oscillator and divider.
// - External mode field picks EC powers, off-and-I/O, reserved, or crystal kinds.
// - Unused word bits read back as one.
//
// The address map and the strobed register port were left to the implementer.
module ocwd_top (
  // Clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                reset_n_i,
  // Non-volatile word source
  input  wire logic [13:0]         nv_word_i,
  input  wire logic                word_valid_i,
  // Register port
  input  wire logic [3:0]          addr_i,
  input  wire logic [15:0]         wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic      [15:0]         rdata_o,
  // To oscillator and switch logic
  output ocwd_pkg::ocwd_cfg_t      cfg_o,
  output logic      [2:0]          new_osc_select_o,
  output logic      [3:0]          new_divider_select_o,
  output logic                     loaded_o,
  output logic                     write_blocked_o,
  // Second oscillator pin
  output logic                     osc2_out_o,
  output logic                     osc2_oe_n_o
);

  // ----------------------------------------------------------------
  // Word capture
  // ----------------------------------------------------------------
  logic [13:0] word_q, word_d;
  logic        loaded_q, loaded_d;
  logic        vld_s1_q, vld_s2_q;
  logic [13:0] nv_s1_q, nv_s2_q;

  // Word and its valid come from the non-volatile array, outside the domain
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      vld_s1_q <= 1'b0;
      vld_s2_q <= 1'b0;
      nv_s1_q  <= ocwd_pkg::ERASED_WORD;
      nv_s2_q  <= ocwd_pkg::ERASED_WORD;
    end
    else
    begin
      vld_s1_q <= word_valid_i;
      vld_s2_q <= vld_s1_q;
      nv_s1_q  <= nv_word_i;
      nv_s2_q  <= nv_s1_q;
    end
  end

  // Captured once per reset; later changes of the array are ignored
  always_comb
  begin
    word_d   = word_q;
    loaded_d = loaded_q;
    if (!loaded_q && vld_s2_q)
    begin
      word_d   = nv_s2_q | ~ocwd_pkg::USED_MASK;
      loaded_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      word_q   <= ocwd_pkg::ERASED_WORD;
      loaded_q <= 1'b0;
    end
    else
    begin
      word_q   <= word_d;
      loaded_q <= loaded_d;
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  ocwd_pkg::ocwd_cfg_t dec;

  ocwd_decode u_decode (
    .word_i (word_q),
    .cfg_o  (dec)
  );

  // ----------------------------------------------------------------
  // Clock switch request registers
  // ----------------------------------------------------------------
  logic [2:0] new_osc_q, new_osc_d;
  logic [3:0] new_div_q, new_div_d;
  logic       blk_q, blk_d;
  logic       ctrl_wr;
  logic       ctrl_ok;

  // Start source follows the reset field; writes need the permit bit
  always_comb
  begin
    ctrl_wr   = wr_i && (addr_i == ocwd_pkg::OFS_OSC_CTRL);
    ctrl_ok   = ctrl_wr && loaded_q && dec.clock_switch_permit;
    new_osc_d = new_osc_q;
    new_div_d = new_div_q;
    blk_d     = blk_q;
    if (vld_s2_q && !loaded_q)
    begin
      new_osc_d = nv_s2_q[ocwd_pkg::RESET_SRC_HI:ocwd_pkg::RESET_SRC_LO];
      new_div_d = ocwd_pkg::NEW_DIV_RESET;
    end
    else if (ctrl_ok)
    begin
      new_osc_d = wdata_i[ocwd_pkg::NEW_OSC_LO +: 3];
      new_div_d = wdata_i[ocwd_pkg::NEW_DIV_LO +: 4];
    end
    // Sticky blocked flag; a refused write in the capture cycle counts too.
    // Cleared by a status read, but a coinciding refusal wins.
    if (ctrl_wr && !ctrl_ok)
    begin
      blk_d = 1'b1;
    end
    else if (rd_i && (addr_i == ocwd_pkg::OFS_STATUS))
    begin
      blk_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      new_osc_q <= ocwd_pkg::NEW_OSC_RESET;
      new_div_q <= ocwd_pkg::NEW_DIV_RESET;
      blk_q     <= 1'b0;
    end
    else
    begin
      new_osc_q <= new_osc_d;
      new_div_q <= new_div_d;
      blk_q     <= blk_d;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [15:0] rdata_q, rdata_d;

  // Unmapped addresses read as zero
  always_comb
  begin
    rdata_d = 16'h0000;
    if (rd_i)
    begin
      if (addr_i == ocwd_pkg::OFS_CFG_WORD)
        rdata_d = {2'b00, word_q};
      else if (addr_i == ocwd_pkg::OFS_OSC_CTRL)
        rdata_d = {8'h00, new_div_q, 1'b0, new_osc_q};
      else if (addr_i == ocwd_pkg::OFS_STATUS)
        rdata_d = {14'h0000, blk_q, loaded_q};
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
      rdata_q <= 16'h0000;
    else
      rdata_q <= rdata_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic [1:0] div4_q, div4_d;
  logic       osc2_out_q, osc2_out_d;
  logic       clk_out_on;

  // Fosc/4 made from the reference; stands in for the system clock here.
  // Pin data is registered, so it trails the enable by one cycle.
  always_comb
  begin
    clk_out_on = loaded_q && dec.fosc4_on_pin;
    div4_d     = div4_q + 2'h1;
    osc2_out_d = clk_out_on && div4_q[1];
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      div4_q     <= 2'h0;
      osc2_out_q <= 1'b0;
    end
    else
    begin
      div4_q     <= div4_d;
      osc2_out_q <= osc2_out_d;
    end
  end

  assign rdata_o              = rdata_q;
  assign cfg_o                = dec;
  assign new_osc_select_o     = new_osc_q;
  assign new_divider_select_o = new_div_q;
  assign loaded_o             = loaded_q;
  assign write_blocked_o      = blk_q;
  // Pin driven only while clock-out is active, held low until loaded
  assign osc2_out_o           = osc2_out_q;
  assign osc2_oe_n_o          = !clk_out_on;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  unused_ones_a : assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (word_q | ocwd_pkg::USED_MASK) == ocwd_pkg::ERASED_WORD)
    else $error("unused word bit read as zero");

  start_source_a : assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    $rose(loaded_q) |-> new_osc_q == word_q[6:4])
    else $error("start source differs from reset field");

  switch_block_a : assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (wr_i && addr_i == ocwd_pkg::OFS_OSC_CTRL && loaded_q && !word_q[11])
      |=> $stable(new_osc_q) && $stable(new_div_q) && blk_q)
    else $error("write passed with switching forbidden");

  switch_write_a : assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (wr_i && addr_i == ocwd_pkg::OFS_OSC_CTRL && loaded_q && word_q[11])
      |=> new_osc_q == $past(wdata_i[2:0]) && new_div_q == $past(wdata_i[7:4]))
    else $error("permitted write not taken");

  field_map_a : assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    cfg_o.failsafe_monitor_enable == word_q[13] && cfg_o.clock_out_enable == word_q[8]
      && cfg_o.external_osc_mode == word_q[2:0])
    else $error("field position wrong");

  pin_io_a : assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    cfg_o.osc_pin_is_io == (word_q[2:0] == 3'h4))
    else $error("oscillator off code misdecoded");

  clkout_pin_a : assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    loaded_q && word_q[2:0] >= 3'h5 && !word_q[8] |-> !osc2_oe_n_o)
    else $error("clock out not driven");

  clkout_off_a : assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (word_q[2:0] < 3'h5 || word_q[8]) |-> osc2_oe_n_o)
    else $error("clock out driven when ignored");

  read_word_a : assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (rd_i && addr_i == ocwd_pkg::OFS_CFG_WORD && loaded_q) |=> rdata_o == {2'b00, word_q})
    else $error("word read wrong");

endmodule // ocwd_top
